//--- mtcwb_defines.vh
// constants for the memory-management, cache and write buffer block
// assumes one core-clock domain; bus beats handshake on the same clock
`ifndef MTCWB_DEFINES_VH
`define MTCWB_DEFINES_VH

// bus burst encodings
`define MTCWB_BURST_SINGLE 3'h0
`define MTCWB_BURST_FOUR_BEAT_INCREMENT_BURST  3'h3
`define MTCWB_BURST_EIGHT_BEAT_WRAP_BURST  3'h4
`define MTCWB_BURST_EIGHT_BEAT_INCREMENT_BURST  3'h5

// fault status causes
`define MTCWB_FS_ALIGN     4'h1
`define MTCWB_FS_TRANS_SEC 4'h5
`define MTCWB_FS_TRANS_PG  4'h7
`define MTCWB_FS_DOM_SEC   4'h9
`define MTCWB_FS_DOM_PG    4'hb
`define MTCWB_FS_PERM_SEC  4'hd
`define MTCWB_FS_PERM_PG   4'hf

// descriptor type fields [1:0]
`define MTCWB_DESC_FAULT   2'h0
`define MTCWB_L1_COARSE    2'h1
`define MTCWB_L1_SECTION   2'h2
`define MTCWB_L1_FINE      2'h3
`define MTCWB_L2_LARGE     2'h1
`define MTCWB_L2_SMALL     2'h2
`define MTCWB_L2_TINY      2'h3

// domain access codes
`define MTCWB_DOM_CLIENT   2'h1
`define MTCWB_DOM_MANAGER  2'h3

// write buffer limits
`define MTCWB_WB_ADDRS     3'h4
`define MTCWB_LAST_BEAT    3'h7

`endif

//--- mtcwb_mmu_cache.v
// translation, access checks, instruction/data caches and write buffers
// assumes the core holds one request until answered; one shared bus master port
`timescale 1ns/10ps
`default_nettype none
`include "mtcwb_defines.vh"

module mtcwb_mmu_cache (
	input  wire        clock_i,
	input  wire        rst_n_i,
	input  wire        mmu_enable_i,
	input  wire        icache_enable_i,
	input  wire        dcache_enable_i,
	input  wire        privileged_i,
	input  wire [31:14] table_base_i,
	input  wire [31:0] domain_access_i,
	input  wire        req_valid_i,
	input  wire        req_instr_i,
	input  wire        req_write_i,
	input  wire [31:0] req_addr_i,
	input  wire [31:0] req_wdata_i,
	output wire        req_ready_o,
	output reg         rsp_valid_o,
	output reg         rsp_abort_o,
	output reg  [31:0] rsp_rdata_o,
	output reg  [7:0]  data_fault_status_o,
	output reg  [31:0] fault_address_o,
	output reg  [7:0]  instr_fault_status_o,
	output reg         bus_valid_o,
	output reg         bus_write_o,
	output reg  [31:0] bus_addr_o,
	output reg  [2:0]  bus_burst_o,
	output reg  [31:0] bus_wdata_o,
	input  wire        bus_ready_i,
	input  wire [31:0] bus_rdata_i
);

// ****************************************
// state and storage
// ****************************************
localparam S_IDLE   = 4'h0;
localparam S_LOOK   = 4'h1;
localparam S_WALK1  = 4'h2;
localparam S_WALK2  = 4'h3;
localparam S_CACHE  = 4'h4;
localparam S_WAIT   = 4'h5;
localparam S_FILL   = 4'h6;
localparam S_SINGLE = 4'h7;
localparam S_ABORT  = 4'h8;

reg [3:0]  state;
reg [3:0]  after_wait;
reg [31:0] modified_virtual_address;
reg [31:0] wdata;
reg        instr;
reg        wr;
reg [31:0] xl_pa;
reg        xl_c;
reg        xl_b;
reg [31:0] walk_addr;
reg [3:0]  walk_dom;
reg [3:0]  f_code;
reg [3:0]  f_dom;

reg [3:0]  tlb_valid;
reg [21:0] tlb_tag [0:3];
reg [21:0] tlb_pa  [0:3];
reg [1:0]  tlb_ap  [0:3];
reg [3:0]  tlb_dom [0:3];
reg [3:0]  tlb_c;
reg [3:0]  tlb_b;
reg [3:0]  tlb_sect;
reg [1:0]  tlb_next;

// line index is {instr, set[5:0], way[1:0]}: 256 lines per cache
reg [31:0]  data_mem  [0:4095];
reg [20:0]  line_tag  [0:511];
reg [26:0]  line_ptag [0:511];
reg [511:0] line_valid;
reg [511:0] dirty_lo;
reg [511:0] dirty_hi;
reg [1:0]   rr;
reg [1:0]   fill_way;
reg [2:0]   fill_cnt;

reg [31:0] ev_data [0:7];
reg [26:0] ev_addr;
reg [1:0]  ev_mask;
reg        ev_valid;
reg        ev_go;
reg [2:0]  ev_beat;

reg [29:0] wb_addr [0:3];
reg [2:0]  wb_cnt  [0:3];
reg [31:0] wb_data [0:15];
reg [1:0]  wb_wr;
reg [1:0]  wb_rd;
reg [2:0]  wb_num;
reg [1:0]  wb_beat;

integer t;
integer w;
integer e;

// ****************************************
// lookups
// ****************************************
function perm_bad;
	input [1:0] ap;
	input       priv;
	input       write;
	begin
		perm_bad = (ap == 2'h0) || (!priv && ((ap == 2'h1) || (ap == 2'h2 && write)));
	end
endfunction

reg       tlb_hit;
reg [1:0] tlb_sel;
always @* begin
	tlb_hit = 1'b0;
	tlb_sel = 2'h0;
	for (t = 0; t < 4; t = t + 1) begin
		if (tlb_valid[t] && tlb_tag[t] == modified_virtual_address[31:10]) begin
			tlb_hit = 1'b1;
			tlb_sel = t[1:0];
		end
	end
end

wire [1:0] dom_bits = domain_access_i[{tlb_dom[tlb_sel], 1'b0} +: 2];

reg       hit;
reg [1:0] hit_way;
always @* begin
	hit = 1'b0;
	hit_way = 2'h0;
	for (w = 0; w < 4; w = w + 1) begin
		if (line_valid[{instr, modified_virtual_address[10:5], w[1:0]}] && line_tag[{instr, modified_virtual_address[10:5], w[1:0]}] == modified_virtual_address[31:11]) begin
			hit = 1'b1;
			hit_way = w[1:0];
		end
	end
end

wire [8:0] cur_line  = {instr, modified_virtual_address[10:5], hit_way};
wire [8:0] vic_line  = {instr, modified_virtual_address[10:5], rr};
wire [8:0] fill_line = {instr, modified_virtual_address[10:5], fill_way};
wire [2:0] fill_word = modified_virtual_address[4:2] + fill_cnt;
wire       vic_dirty = line_valid[vic_line] && (dirty_lo[vic_line] || dirty_hi[vic_line]);
wire       cache_on  = (instr ? icache_enable_i : dcache_enable_i) && xl_c;

// walk result decode, shared by both levels
reg [21:0] fill_pa;
reg [1:0]  fill_ap;
reg [3:0]  fill_dom;
reg        fill_sect;
reg [7:0]  ap_word;
reg        tlb_load;
always @* begin
	fill_pa = {bus_rdata_i[31:20], modified_virtual_address[19:10]};
	fill_ap = bus_rdata_i[11:10];
	fill_dom = bus_rdata_i[8:5];
	fill_sect = 1'b1;
	ap_word = bus_rdata_i[11:4];
	if (state == S_WALK2) begin
		fill_dom = walk_dom;
		fill_sect = 1'b0;
		case (bus_rdata_i[1:0])
			`MTCWB_L2_LARGE: begin
				fill_pa = {bus_rdata_i[31:16], modified_virtual_address[15:10]};
				ap_word = bus_rdata_i[11:4] >> {modified_virtual_address[15:14], 1'b0};
				fill_ap = ap_word[1:0];
			end
			`MTCWB_L2_SMALL: begin
				fill_pa = {bus_rdata_i[31:12], modified_virtual_address[11:10]};
				ap_word = bus_rdata_i[11:4] >> {modified_virtual_address[11:10], 1'b0};
				fill_ap = ap_word[1:0];
			end
			default: begin
				fill_pa = bus_rdata_i[31:10];
				fill_ap = bus_rdata_i[5:4];
			end
		endcase
	end
	tlb_load = bus_ready_i && ((state == S_WALK1 && bus_rdata_i[1:0] == `MTCWB_L1_SECTION) ||
		(state == S_WALK2 && bus_rdata_i[1:0] != `MTCWB_DESC_FAULT));
end

// ****************************************
// buffer drain control
// ****************************************
wire       main_bus = (state == S_WALK1) || (state == S_WALK2) || (state == S_FILL) ||
	(state == S_SINGLE);
// a started line write-back keeps the bus until its last beat
wire       dr_ev   = !main_bus && ev_valid && (ev_go || wb_num == 3'h0);
wire       dr_wb   = !main_bus && !dr_ev && wb_num != 3'h0;
wire       ev_last = ev_beat == ((ev_mask == 2'b01) ? 3'h3 : `MTCWB_LAST_BEAT);
wire [2:0] wb_hd_cnt = wb_cnt[wb_rd];
wire       wb_last = {1'b0, wb_beat} == wb_hd_cnt - 3'h1;
wire       wb_pop  = dr_wb && bus_ready_i && wb_last;
wire [1:0] wb_tail = wb_wr - 2'h1;
wire [29:0] tail_addr = wb_addr[wb_tail];
wire [2:0] tail_cnt = wb_cnt[wb_tail];
// merge only into an entry the drainer has not started
wire       wb_merge = (wb_num >= 3'h2) && tail_addr[29:2] == xl_pa[31:4] &&
	({1'b0, tail_addr[1:0]} + tail_cnt) == {1'b0, xl_pa[3:2]};
wire       wb_room = wb_merge || wb_num != `MTCWB_WB_ADDRS;
wire       wb_push = (state == S_CACHE) && wr && (xl_b || xl_c) && !(cache_on && hit && xl_b) &&
	wb_room;
wire [1:0] tail_slot = tail_addr[1:0] + tail_cnt[1:0];
wire [29:0] hd_addr = wb_addr[wb_rd];
wire [1:0] hd_slot = hd_addr[1:0] + wb_beat;

assign req_ready_o = (state == S_IDLE);

// ****************************************
// bus master mux
// ****************************************
always @* begin
	bus_valid_o = main_bus || dr_ev || dr_wb;
	bus_write_o = 1'b0;
	bus_addr_o = walk_addr;
	bus_burst_o = `MTCWB_BURST_SINGLE;
	bus_wdata_o = 32'h0;
	case (state)
		S_WALK1, S_WALK2: bus_write_o = 1'b0;
		S_FILL: begin
			bus_addr_o = {xl_pa[31:5], fill_word, 2'b00};
			bus_burst_o = `MTCWB_BURST_EIGHT_BEAT_WRAP_BURST;
		end
		S_SINGLE: begin
			bus_addr_o = xl_pa;
			bus_write_o = wr;
			bus_wdata_o = wdata;
		end
		default: begin
			if (dr_ev) begin
				bus_write_o = 1'b1;
				bus_addr_o = {ev_addr, ev_beat, 2'b00};
				bus_burst_o = (ev_mask == 2'b11) ? `MTCWB_BURST_EIGHT_BEAT_INCREMENT_BURST : `MTCWB_BURST_FOUR_BEAT_INCREMENT_BURST;
				bus_wdata_o = ev_data[ev_beat];
			end else if (dr_wb) begin
				bus_write_o = 1'b1;
				bus_addr_o = {hd_addr + {28'h0, wb_beat}, 2'b00};
				bus_burst_o = (wb_hd_cnt == 3'h4) ? `MTCWB_BURST_FOUR_BEAT_INCREMENT_BURST : `MTCWB_BURST_SINGLE;
				bus_wdata_o = wb_data[{wb_rd, hd_slot}];
			end
		end
	endcase
end

// ****************************************
// controller
// ****************************************
always @(posedge clock_i) begin
	if (!rst_n_i) begin
		state <= S_IDLE;
		after_wait <= S_IDLE;
		modified_virtual_address <= 32'h0;
		wdata <= 32'h0;
		instr <= 1'b0;
		wr <= 1'b0;
		xl_pa <= 32'h0;
		xl_c <= 1'b0;
		xl_b <= 1'b0;
		walk_addr <= 32'h0;
		walk_dom <= 4'h0;
		f_code <= 4'h0;
		f_dom <= 4'h0;
		rsp_valid_o <= 1'b0;
		rsp_abort_o <= 1'b0;
		rsp_rdata_o <= 32'h0;
		data_fault_status_o <= 8'h0;
		fault_address_o <= 32'h0;
		instr_fault_status_o <= 8'h0;
		tlb_valid <= 4'h0;
		tlb_next <= 2'h0;
		line_valid <= 512'h0;
		dirty_lo <= 512'h0;
		dirty_hi <= 512'h0;
		rr <= 2'h0;
		fill_way <= 2'h0;
		fill_cnt <= 3'h0;
		ev_valid <= 1'b0;
		ev_go <= 1'b0;
		ev_beat <= 3'h0;
		ev_mask <= 2'h0;
		ev_addr <= 27'h0;
		wb_wr <= 2'h0;
		wb_rd <= 2'h0;
		wb_num <= 3'h0;
		wb_beat <= 2'h0;
	end else begin
		rsp_valid_o <= 1'b0;
		rsp_abort_o <= 1'b0;
		// write-back buffer drain
		if (dr_ev) begin
			ev_go <= 1'b1;
			if (bus_ready_i) begin
				if (ev_last) begin
					ev_valid <= 1'b0;
					ev_go <= 1'b0;
				end else begin
					ev_beat <= ev_beat + 3'h1;
				end
			end
		end
		// write buffer drain and fill; a store with C or B set waits for the bus only when all four entries are taken and no merge fits
		if (dr_wb && bus_ready_i) begin
			wb_beat <= wb_last ? 2'h0 : wb_beat + 2'h1;
			if (wb_last)
				wb_rd <= wb_rd + 2'h1;
		end
		if (wb_push) begin
			if (wb_merge) begin
				wb_data[{wb_tail, tail_slot}] <= wdata;
				wb_cnt[wb_tail] <= tail_cnt + 3'h1;
			end else begin
				wb_addr[wb_wr] <= xl_pa[31:2];
				wb_cnt[wb_wr] <= 3'h1;
				wb_data[{wb_wr, xl_pa[3:2]}] <= wdata;
				wb_wr <= wb_wr + 2'h1;
			end
		end
		case ({wb_push && !wb_merge, wb_pop})
			2'b10: wb_num <= wb_num + 3'h1;
			2'b01: wb_num <= wb_num - 3'h1;
			default: wb_num <= wb_num;
		endcase
		if (tlb_load) begin
			tlb_valid[tlb_next] <= 1'b1;
			tlb_tag[tlb_next] <= modified_virtual_address[31:10];
			tlb_pa[tlb_next] <= fill_pa;
			tlb_ap[tlb_next] <= fill_ap;
			tlb_dom[tlb_next] <= fill_dom;
			tlb_c[tlb_next] <= bus_rdata_i[3];
			tlb_b[tlb_next] <= bus_rdata_i[2];
			tlb_sect[tlb_next] <= fill_sect;
			tlb_next <= tlb_next + 2'h1;
		end
		case (state)
			S_IDLE: begin
				if (req_valid_i) begin
					modified_virtual_address <= req_addr_i;
					instr <= req_instr_i;
					wr <= req_write_i && !req_instr_i;
					wdata <= req_wdata_i;
					state <= S_LOOK;
				end
			end
			S_LOOK: begin
				walk_addr <= {table_base_i, modified_virtual_address[31:20], 2'b00};
				if (!mmu_enable_i) begin
					xl_pa <= modified_virtual_address;
					xl_c <= instr;
					xl_b <= 1'b0;
					state <= S_CACHE;
				end else if (!instr && modified_virtual_address[1:0] != 2'b00) begin
					f_code <= `MTCWB_FS_ALIGN;
					f_dom <= 4'h0;
					state <= S_ABORT;
				end else if (!tlb_hit) begin
					after_wait <= S_WALK1;
					state <= S_WAIT;
				end else if (dom_bits != `MTCWB_DOM_CLIENT && dom_bits != `MTCWB_DOM_MANAGER) begin
					f_code <= tlb_sect[tlb_sel] ? `MTCWB_FS_DOM_SEC : `MTCWB_FS_DOM_PG;
					f_dom <= tlb_dom[tlb_sel];
					state <= S_ABORT;
				end else if (dom_bits == `MTCWB_DOM_CLIENT && perm_bad(tlb_ap[tlb_sel], privileged_i, wr)) begin
					f_code <= tlb_sect[tlb_sel] ? `MTCWB_FS_PERM_SEC : `MTCWB_FS_PERM_PG;
					f_dom <= tlb_dom[tlb_sel];
					state <= S_ABORT;
				end else begin
					xl_pa <= {tlb_pa[tlb_sel], modified_virtual_address[9:0]};
					xl_c <= tlb_c[tlb_sel];
					xl_b <= tlb_b[tlb_sel];
					state <= S_CACHE;
				end
			end
			S_WALK1: begin
				if (bus_ready_i) begin
					walk_dom <= bus_rdata_i[8:5];
					case (bus_rdata_i[1:0])
						`MTCWB_L1_SECTION: state <= S_LOOK;
						`MTCWB_L1_COARSE: begin
							walk_addr <= {bus_rdata_i[31:10], modified_virtual_address[19:12], 2'b00};
							state <= S_WALK2;
						end
						`MTCWB_L1_FINE: begin
							walk_addr <= {bus_rdata_i[31:12], modified_virtual_address[19:10], 2'b00};
							state <= S_WALK2;
						end
						default: begin
							f_code <= `MTCWB_FS_TRANS_SEC;
							f_dom <= 4'h0;
							state <= S_ABORT;
						end
					endcase
				end
			end
			S_WALK2: begin
				if (bus_ready_i) begin
					if (bus_rdata_i[1:0] == `MTCWB_DESC_FAULT) begin
						f_code <= `MTCWB_FS_TRANS_PG;
						f_dom <= walk_dom;
						state <= S_ABORT;
					end else begin
						state <= S_LOOK;
					end
				end
			end
			S_CACHE: begin
				if (cache_on && hit) begin
					if (!wr || xl_b || wb_room) begin
						if (wr)
							data_mem[{cur_line, modified_virtual_address[4:2]}] <= wdata;
						if (wr && xl_b && modified_virtual_address[4])
							dirty_hi[cur_line] <= 1'b1;
						if (wr && xl_b && !modified_virtual_address[4])
							dirty_lo[cur_line] <= 1'b1;
						rsp_rdata_o <= wr ? 32'h0 : data_mem[{cur_line, modified_virtual_address[4:2]}];
						rsp_valid_o <= 1'b1;
						state <= S_IDLE;
					end
				end else if (!wr && cache_on) begin
					// one eviction slot: a second dirty victim waits for it
					if (!vic_dirty || !ev_valid) begin
						if (vic_dirty) begin
							for (e = 0; e < 8; e = e + 1)
								ev_data[e] <= data_mem[{vic_line, e[2:0]}];
							ev_addr <= line_ptag[vic_line];
							ev_mask <= {dirty_hi[vic_line], dirty_lo[vic_line]};
							ev_beat <= dirty_lo[vic_line] ? 3'h0 : 3'h4;
							ev_valid <= 1'b1;
						end
						line_valid[vic_line] <= 1'b0;
						fill_way <= rr;
						fill_cnt <= 3'h0;
						after_wait <= S_FILL;
						state <= S_WAIT;
					end
				end else if (wr && (xl_b || xl_c)) begin
					if (wb_room) begin
						rsp_valid_o <= 1'b1;
						rsp_rdata_o <= 32'h0;
						state <= S_IDLE;
					end
				end else begin
					after_wait <= S_SINGLE;
					state <= S_WAIT;
				end
			end
			S_WAIT: begin
				// bus reads never overtake queued writes
				if (wb_num == 3'h0 && !ev_valid)
					state <= after_wait;
			end
			S_FILL: begin
				if (bus_ready_i) begin
					data_mem[{fill_line, fill_word}] <= bus_rdata_i;
					fill_cnt <= fill_cnt + 3'h1;
					if (fill_cnt == 3'h0) begin
						rsp_rdata_o <= bus_rdata_i;
						rsp_valid_o <= 1'b1;
					end
					if (fill_cnt == `MTCWB_LAST_BEAT) begin
						line_valid[fill_line] <= 1'b1;
						line_tag[fill_line] <= modified_virtual_address[31:11];
						line_ptag[fill_line] <= xl_pa[31:5];
						dirty_lo[fill_line] <= 1'b0;
						dirty_hi[fill_line] <= 1'b0;
						rr <= rr + 2'h1;
						state <= S_IDLE;
					end
				end
			end
			S_SINGLE: begin
				if (bus_ready_i) begin
					rsp_rdata_o <= wr ? 32'h0 : bus_rdata_i;
					rsp_valid_o <= 1'b1;
					state <= S_IDLE;
				end
			end
			S_ABORT: begin
				// no fill and no single access reach here; only the lookup and the table-walk reads do
				if (instr) begin
					instr_fault_status_o <= {f_dom, f_code};
				end else begin
					data_fault_status_o <= {f_dom, f_code};
					fault_address_o <= modified_virtual_address;
				end
				rsp_abort_o <= 1'b1;
				rsp_valid_o <= 1'b1;
				rsp_rdata_o <= 32'h0;
				state <= S_IDLE;
			end
			default: state <= S_IDLE;
		endcase
	end
end

endmodule
`default_nettype wire

//--- mtcwb_mmu_cache_properties.sv
// concurrent checks on the ports of mtcwb_mmu_cache
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
`include "mtcwb_defines.vh"
module mtcwb_mmu_cache_props (
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        req_valid_i,
	input wire logic        req_ready_o,
	input wire logic        rsp_valid_o,
	input wire logic        rsp_abort_o,
	input wire logic [31:0] fault_address_o,
	input wire logic        bus_valid_o,
	input wire logic        bus_ready_i,
	input wire logic        bus_write_o,
	input wire logic [31:0] bus_addr_o,
	input wire logic [2:0]  bus_burst_o
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence take;
		req_valid_i && req_ready_o;
	endsequence
	sequence wrap_beat;
		bus_valid_o && bus_ready_i && bus_burst_o == `MTCWB_BURST_EIGHT_BEAT_WRAP_BURST;
	endsequence
	sequence wrap_next;
		bus_valid_o && bus_burst_o == `MTCWB_BURST_EIGHT_BEAT_WRAP_BURST;
	endsequence
	// reset itself is the antecedent, so no disable here
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=>
		req_ready_o && !rsp_valid_o && !bus_valid_o) else $error("reset state wrong");
	a_abort_valid: assert property (rsp_abort_o |-> rsp_valid_o)
		else $error("abort without answer");
	a_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
		else $error("answer longer than one cycle");
	a_take_busy: assert property (take |=> !req_ready_o)
		else $error("ready after take");
	a_answer_bound: assert property (take |-> ##[2:400] rsp_valid_o)
		else $error("answer missing");
	a_bus_hold: assert property (bus_valid_o && !bus_ready_i |=> bus_valid_o
		&& $stable(bus_addr_o) && $stable(bus_burst_o) && $stable(bus_write_o))
		else $error("bus request changed while stalled");
	a_burst_legal: assert property (bus_valid_o |-> bus_burst_o inside
		{`MTCWB_BURST_SINGLE, `MTCWB_BURST_FOUR_BEAT_INCREMENT_BURST, `MTCWB_BURST_EIGHT_BEAT_WRAP_BURST, `MTCWB_BURST_EIGHT_BEAT_INCREMENT_BURST})
		else $error("illegal burst code");
	a_wrap_order: assert property (wrap_beat ##1 wrap_next |-> bus_addr_o ==
		{$past(bus_addr_o[31:5]), $past(bus_addr_o[4:2]) + 3'h1, 2'h0})
		else $error("fill beat out of order");
	a_fault_cause: assert property ($changed(fault_address_o) && $past(rst_n_i) |->
		($past(rsp_abort_o) or ##[0:1] rsp_abort_o)) else $error("fault address without abort");
endmodule
bind mtcwb_mmu_cache mtcwb_mmu_cache_props u_props (.clock_i, .rst_n_i, .req_valid_i,
	.req_ready_o, .rsp_valid_o, .rsp_abort_o, .fault_address_o, .bus_valid_o, .bus_ready_i,
	.bus_write_o, .bus_addr_o, .bus_burst_o);
`default_nettype wire

//--- mtcwb_bus_model.sv
// behavioural system-bus memory for the block's master port
// assumes word addresses; stall sets wait cycles before each beat
`timescale 1ns/10ps
`default_nettype none
module mtcwb_bus_model (
	input  wire logic        clock_i,
	input  wire logic        rst_n_i,
	input  wire logic        bus_valid_i,
	input  wire logic        bus_write_i,
	input  wire logic [31:0] bus_addr_i,
	input  wire logic [2:0]  bus_burst_i,
	input  wire logic [31:0] bus_wdata_i,
	output var  logic        bus_ready_o,
	output var  logic [31:0] bus_rdata_o
);
	// ****
	// memory and beat log
	// ****
	int          stall;
	int          wait_cnt;
	logic [31:0] mem [logic [31:0]];
	logic [31:0] log_addr [$];
	logic [2:0]  log_burst [$];
	task automatic clear_log();
		log_addr.delete();
		log_burst.delete();
	endtask
	initial begin
		stall = 0;
		bus_ready_o = 1'b0;
		bus_rdata_o = 32'h0;
	end
	// read data is only valid with ready; otherwise it toggles so stale use shows
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			bus_ready_o <= 1'b0;
			wait_cnt <= 0;
		end else if (bus_ready_o) begin
			bus_ready_o <= 1'b0;
			bus_rdata_o <= ~bus_rdata_o;
			if (bus_valid_i) begin
				log_addr.push_back(bus_addr_i);
				log_burst.push_back(bus_burst_i);
				if (bus_write_i) mem[bus_addr_i] = bus_wdata_i;
			end
		end else if (bus_valid_i && wait_cnt >= stall) begin
			bus_ready_o <= 1'b1;
			bus_rdata_o <= mem.exists(bus_addr_i) ? mem[bus_addr_i] : bus_addr_i ^ 32'h5aa5c33c;
			wait_cnt <= 0;
		end else begin
			bus_rdata_o <= ~bus_rdata_o;
			wait_cnt <= bus_valid_i ? wait_cnt + 1 : 0;
		end
	end
endmodule
`default_nettype wire

//--- mtcwb_mmu_cache_bench.sv
// self-checking bench for mtcwb_mmu_cache
// assumes mtcwb_bus_model as the bus; inputs change on the falling edge
`timescale 1ns/10ps
`default_nettype none
`include "mtcwb_defines.vh"
module mtcwb_mmu_cache_bench;
	logic         clock_i, rst_n_i, mmu_enable_i, icache_enable_i, dcache_enable_i;
	logic         privileged_i, req_valid_i, req_instr_i, req_write_i, req_ready_o;
	logic         rsp_valid_o, rsp_abort_o, bus_valid_o, bus_write_o, bus_ready_i, ab;
	logic [31:14] table_base_i;
	logic [31:0]  domain_access_i, req_addr_i, req_wdata_i, rsp_rdata_o, fault_address_o;
	logic [31:0]  bus_addr_o, bus_wdata_o, bus_rdata_i, rd;
	logic [7:0]   data_fault_status_o, instr_fault_status_o;
	logic [2:0]   bus_burst_o;
	int           bad_count, samples_checked, lat;
	mtcwb_mmu_cache dut (.clock_i, .rst_n_i, .mmu_enable_i, .icache_enable_i, .dcache_enable_i,
		.privileged_i, .table_base_i, .domain_access_i, .req_valid_i, .req_instr_i,
		.req_write_i, .req_addr_i, .req_wdata_i, .req_ready_o, .rsp_valid_o, .rsp_abort_o,
		.rsp_rdata_o, .data_fault_status_o, .fault_address_o, .instr_fault_status_o,
		.bus_valid_o, .bus_write_o, .bus_addr_o, .bus_burst_o, .bus_wdata_o, .bus_ready_i,
		.bus_rdata_i);
	mtcwb_bus_model far (.clock_i, .rst_n_i, .bus_valid_i(bus_valid_o),
		.bus_write_i(bus_write_o), .bus_addr_i(bus_addr_o), .bus_burst_i(bus_burst_o),
		.bus_wdata_i(bus_wdata_o), .bus_ready_o(bus_ready_i), .bus_rdata_o(bus_rdata_i));
	initial clock_i = 1'b0;
	always #5 clock_i = ~clock_i;
	// ****
	// helpers
	// ****
	function automatic logic [31:0] pat(input logic [31:0] a);
		return a ^ 32'h5aa5c33c;
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one core request, held until taken; called and left at a falling edge
	task automatic access(input logic i, input logic w, input logic [31:0] a, d);
		int n;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 500) begin
			@(negedge clock_i);
			n++;
		end
		req_valid_i = 1'b1;
		req_instr_i = i;
		req_write_i = w;
		req_addr_i = a;
		req_wdata_i = d;
		@(negedge clock_i);
		req_valid_i = 1'b0;
		lat = 0;
		while (rsp_valid_o !== 1'b1 && lat < 500) begin
			@(negedge clock_i);
			lat++;
		end
		chk(lat < 500, 32'h1);
		ab = rsp_abort_o;
		rd = rsp_rdata_o;
		@(negedge clock_i);
	endtask
	// ****
	// scenarios
	// ****
	task automatic t_flat();
		far.clear_log();
		access(1'b0, 1'b1, 32'h2000, 32'hdeadbeef);
		access(1'b0, 1'b0, 32'h2000, 32'h0);
		chk(rd, 32'hdeadbeef);
		chk(far.log_addr.size(), 32'h2);
		chk(far.log_addr[1], 32'h2000);
		chk(far.log_burst[1], `MTCWB_BURST_SINGLE);
		far.clear_log();
		access(1'b1, 1'b0, 32'h3000, 32'h0);
		access(1'b1, 1'b0, 32'h3000, 32'h0);
		chk(far.log_addr.size(), 32'h2);
		chk(rd, pat(32'h3000));
	endtask
	task automatic t_ifill();
		icache_enable_i = 1'b1;
		far.clear_log();
		access(1'b1, 1'b0, 32'h4014, 32'h0);
		chk(rd, pat(32'h4014));
		access(1'b1, 1'b0, 32'h4008, 32'h0);
		chk(rd, pat(32'h4008));
		chk(far.log_addr.size(), 32'h8);
		for (int k = 0; k < 8; k++) begin
			chk(far.log_addr[k], 32'h4000 + ((k + 5) % 8) * 4);
			chk(far.log_burst[k], `MTCWB_BURST_EIGHT_BEAT_WRAP_BURST);
		end
		icache_enable_i = 1'b0;
		far.clear_log();
		access(1'b1, 1'b0, 32'h4008, 32'h0);
		chk(far.log_addr.size(), 32'h1);
	endtask
	task automatic t_walk();
		far.mem[32'h1000c] = 32'h00500c22;
		far.mem[32'h10018] = 32'h00020021;
		far.mem[32'h20004] = 32'h00700ff2;
		far.mem[32'h1002c] = 32'h00b00062;
		far.clear_log();
		access(1'b0, 1'b0, 32'h00300010, 32'h0);
		chk(far.log_addr[0], 32'h1000c);
		chk(far.log_addr.size(), 32'h2);
		chk(rd, pat(32'h00500010));
		access(1'b0, 1'b0, 32'h00300020, 32'h0);
		chk(far.log_addr.size(), 32'h3);
		chk(far.log_addr[2], 32'h00500020);
		far.clear_log();
		access(1'b0, 1'b0, 32'h00601404, 32'h0);
		chk(far.log_addr.size(), 32'h3);
		chk(far.log_addr[1], 32'h20004);
		chk(rd, pat(32'h00700404));
		access(1'b0, 1'b0, 32'h00b00000, 32'h0);
		chk(ab, 32'h0);
		chk(rd, pat(32'h00b00000));
	endtask
	task automatic fcase(input logic i, input logic [31:0] a, input logic [7:0] m, e,
		input int nb);
		far.clear_log();
		access(i, 1'b0, a, 32'h0);
		chk(ab, 32'h1);
		chk(far.log_addr.size(), nb);
		if (i) chk(instr_fault_status_o & m, e);
		else begin
			chk(data_fault_status_o & m, e);
			chk(fault_address_o, a);
		end
	endtask
	task automatic t_faults();
		far.mem[32'h10020] = 32'h00800c42;
		far.mem[32'h10024] = 32'h0;
		far.mem[32'h10028] = 32'h00a00022;
		far.mem[32'h20008] = 32'h0;
		fcase(1'b0, 32'h00602000, 8'hff, {4'h1, `MTCWB_FS_TRANS_PG}, 2);
		fcase(1'b0, 32'h00300012, 8'h0f, {4'h0, `MTCWB_FS_ALIGN}, 0);
		fcase(1'b0, 32'h00800000, 8'hff, {4'h2, `MTCWB_FS_DOM_SEC}, 1);
		fcase(1'b0, 32'h00900000, 8'hff, {4'h0, `MTCWB_FS_TRANS_SEC}, 1);
		fcase(1'b1, 32'h00a00000, 8'hff, {4'h1, `MTCWB_FS_PERM_SEC}, 1);
		chk(data_fault_status_o, {4'h0, `MTCWB_FS_TRANS_SEC});
	endtask
	// bufferable stores must answer quickly while the bus crawls
	task automatic t_wbuf();
		far.mem[32'h10030] = 32'h00c00c26;
		access(1'b0, 1'b0, 32'h00c00000, 32'h0);
		far.stall = 6;
		for (int k = 0; k < 4; k++) begin
			access(1'b0, 1'b1, 32'h00c00000 + k * 4, 32'h11110000 + k);
			chk(lat < 4, 32'h1);
		end
		far.stall = 0;
		access(1'b0, 1'b0, 32'h00c00008, 32'h0);
		chk(rd, 32'h11110002);
	endtask
	// dirty low half leaves as one four-beat burst at the physical tag
	// a hit after a fill lets its last beats land before the log is cleared
	task automatic t_dirty();
		far.mem[32'h10034] = 32'h00e00c2e;
		access(1'b0, 1'b0, 32'h00d00000, 32'h0);
		chk(rd, pat(32'h00e00000));
		access(1'b0, 1'b0, 32'h00d00000, 32'h0);
		far.clear_log();
		access(1'b0, 1'b1, 32'h00d00004, 32'hcafe0001);
		access(1'b0, 1'b0, 32'h00d00004, 32'h0);
		chk(rd, 32'hcafe0001);
		chk(far.log_addr.size(), 32'h0);
		for (int k = 1; k < 4; k++)
			access(1'b0, 1'b0, 32'h00d00000 + k * 32'h800, 32'h0);
		access(1'b0, 1'b0, 32'h00d01800, 32'h0);
		far.clear_log();
		access(1'b0, 1'b0, 32'h00d02000, 32'h0);
		access(1'b0, 1'b0, 32'h00d02000, 32'h0);
		chk(far.log_addr.size(), 32'hd);
		chk(far.log_addr[1], 32'h00e00000);
		chk(far.log_addr[4], 32'h00e0000c);
		chk(far.log_burst[1], `MTCWB_BURST_FOUR_BEAT_INCREMENT_BURST);
		chk(far.mem[32'h00e00004], 32'hcafe0001);
	endtask
	initial begin
		{rst_n_i, mmu_enable_i, icache_enable_i, req_valid_i, req_instr_i, req_write_i} = 6'h0;
		{req_addr_i, req_wdata_i} = 64'h0;
		{dcache_enable_i, privileged_i} = 2'h3;
		table_base_i = 18'h4;
		domain_access_i = 32'hc4;
		repeat (12) @(negedge clock_i);
		rst_n_i = 1'b1;
		@(negedge clock_i);
		chk({req_ready_o, rsp_valid_o, bus_valid_o}, 32'h4);
		chk(fault_address_o, 32'h0);
		t_flat();
		t_ifill();
		mmu_enable_i = 1'b1;
		t_walk();
		t_faults();
		t_wbuf();
		t_dirty();
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		bad_count++;
		stop_test();
	end
endmodule
`default_nettype wire
